/* rtl/ifel_consts.svh */
// Purpose: timing and width constants for the fast input front end
// Assumes: core_clk at 100 MHz
// Notes:   counts derived from times in their own units
`ifndef IFEL_CONSTS_SVH
`define IFEL_CONSTS_SVH
`define IFEL_CLK_MHZ          100
`define IFEL_NUM_INPUTS       8
`define IFEL_NUM_IRQ          6
`define IFEL_FAST_LO_US       5
`define IFEL_FAST_HI_US       50
`define IFEL_DEFAULT_MS       10
`define IFEL_DELAY_STEP_MS    1
`define IFEL_FAST_LO_CYC      (`IFEL_FAST_LO_US * `IFEL_CLK_MHZ)
`define IFEL_FAST_HI_CYC      (`IFEL_FAST_HI_US * `IFEL_CLK_MHZ)
`define IFEL_DEFAULT_CYC      (`IFEL_DEFAULT_MS * 1000 * `IFEL_CLK_MHZ)
`define IFEL_STEP_CYC         (`IFEL_DELAY_STEP_MS * 1000 * `IFEL_CLK_MHZ)
`define IFEL_CNT_W            20
`define IFEL_DELAY_W          8
`endif

/* rtl/ifel_pkg.sv */
// Purpose: shared types for the fast input front end
// Assumes: ifel_consts.svh provides widths
// Notes:   none
`include "ifel_consts.svh"
package ifel_pkg;
  typedef logic [`IFEL_NUM_INPUTS-1:0] ifel_vec_t;
  typedef struct packed {
    logic [`IFEL_NUM_IRQ-1:0] rise;
    logic [`IFEL_NUM_IRQ-1:0] fall;
  } ifel_irq_t;
  typedef enum logic [1:0] {
    IFEL_IDLE = 2'b01,
    IFEL_WAIT = 2'b10
  } ifel_dly_st_t;
endpackage : ifel_pkg

/* rtl/ifel_filter.sv */
// Purpose: one input noise filter, output follows input after a stable run
// Assumes: input already synchronised to core_clk
// Notes:   length counted in core_clk cycles
`timescale 1ns/100ps
`default_nettype none
module ifel_filter #(
  parameter int CNT_W = 20
) (
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic             din,
  input  wire logic [CNT_W-1:0] len,
  output logic                  dout
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             out_r;
  logic             out_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    out_nxt = out_r;
    if (din == out_r) begin
      cnt_nxt = '0;
    end else if (cnt_r + 1'b1 >= len) begin
      out_nxt = din;
      cnt_nxt = '0;
    end else begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
      out_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign dout = out_r;
endmodule : ifel_filter
`default_nettype wire

/* rtl/ifel_top.sv */
// Purpose: filters, edge interrupts with delay, pulse latches of fast inputs
// Assumes: one 100 MHz clock, pins asynchronous to it
// Notes:   outputs forced off on a watchdog timeout
//
// How it works
// - counter-assigned inputs use 5 us filter (0..5) or 50 us (6,7)
// - other inputs keep the default 10 ms filter
// - six edge inputs, rise and fall pulses, each with a disable flag
// - interrupt start delayed by a program-set count of 1 ms steps
// - eight pulse inputs each set their own readable latch flag
// - watchdog timeout drives every output off
`timescale 1ns/100ps
`default_nettype none
`include "ifel_consts.svh"
module ifel_top
  import ifel_pkg::*;
#(
  parameter int                   NI         = `IFEL_NUM_INPUTS,
  parameter int                   NQ         = `IFEL_NUM_IRQ,
  parameter logic [`IFEL_CNT_W-1:0] DEF_CYC  = `IFEL_CNT_W'(`IFEL_DEFAULT_CYC),
  parameter logic [`IFEL_CNT_W-1:0] STEP_CYC = `IFEL_CNT_W'(`IFEL_STEP_CYC)
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst_b,
  input  wire logic [NI-1:0]          fast_input_pin,
  input  wire logic [NI-1:0]          counter_assign,
  input  wire logic [NQ-1:0]          edge_irq_disable_flag,
  input  wire logic [`IFEL_DELAY_W-1:0] irq_delay_ms,
  input  wire logic [NI-1:0]          pulse_latch_clear,
  input  wire logic                   watchdog_timeout,
  output logic [NI-1:0]               filtered_input,
  output ifel_irq_t                   edge_irq_vector,
  output logic [NI-1:0]               pulse_latch_flag
);
  // --------------------------------------------------------------
  // synchronisers
  // --------------------------------------------------------------
  logic [NI-1:0] sync1_r;
  logic [NI-1:0] sync2_r;
  logic [NI-1:0] filt;
  logic [NI-1:0] filt_d_r;
  logic [NI-1:0] rise_ev;
  logic [NI-1:0] fall_ev;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= fast_input_pin;
      sync2_r <= sync1_r;
    end
  end

  // --------------------------------------------------------------
  // filters
  // --------------------------------------------------------------
  function automatic logic [`IFEL_CNT_W-1:0] flen(input int idx, input logic cnt_use);
    logic [`IFEL_CNT_W-1:0] v;
    v = DEF_CYC;
    if (cnt_use) begin
      v = (idx < 6) ? `IFEL_CNT_W'(`IFEL_FAST_LO_CYC) : `IFEL_CNT_W'(`IFEL_FAST_HI_CYC);
    end
    return v;
  endfunction : flen

  genvar g;
  generate
    for (g = 0; g < NI; g++) begin : g_flt
      ifel_filter #(.CNT_W(`IFEL_CNT_W)) u_flt (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .din      (sync2_r[g]),
        .len      (flen(g, counter_assign[g])),
        .dout     (filt[g])
      );
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      filt_d_r <= '0;
    end else begin
      filt_d_r <= filt;
    end
  end
  assign rise_ev = filt & ~filt_d_r;
  assign fall_ev = ~filt & filt_d_r;

  // --------------------------------------------------------------
  // 1 ms tick
  // --------------------------------------------------------------
  logic [`IFEL_CNT_W-1:0] tick_cnt_r;
  logic [`IFEL_CNT_W-1:0] tick_cnt_nxt;
  logic                   tick;
  always_comb begin
    tick         = (tick_cnt_r + 1'b1 >= STEP_CYC);
    tick_cnt_nxt = tick ? '0 : tick_cnt_r + 1'b1;
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
    end
  end

  // --------------------------------------------------------------
  // edge interrupts with delay
  // --------------------------------------------------------------
  ifel_dly_st_t           st_r   [2*NQ];
  ifel_dly_st_t           st_nxt [2*NQ];
  logic [`IFEL_DELAY_W-1:0] dly_r  [2*NQ];
  logic [`IFEL_DELAY_W-1:0] dly_nxt[2*NQ];
  logic [2*NQ-1:0]        fire;
  logic [2*NQ-1:0]        ev;
  logic [2*NQ-1:0]        dis;

  // a disabled input drops edges; pending delays are also cancelled
  assign ev  = {fall_ev[NQ-1:0], rise_ev[NQ-1:0]};
  assign dis = {edge_irq_disable_flag, edge_irq_disable_flag};

  always_comb begin
    for (int i = 0; i < 2*NQ; i++) begin
      st_nxt[i]  = st_r[i];
      dly_nxt[i] = dly_r[i];
      fire[i]    = 1'b0;
      case (st_r[i])
        IFEL_IDLE: begin
          if (ev[i] && !dis[i]) begin
            if (irq_delay_ms == '0) begin
              fire[i] = 1'b1;
            end else begin
              st_nxt[i]  = IFEL_WAIT;
              dly_nxt[i] = irq_delay_ms;
            end
          end
        end
        IFEL_WAIT: begin
          if (dis[i]) begin
            st_nxt[i] = IFEL_IDLE;
          end else if (tick) begin
            if (dly_r[i] == `IFEL_DELAY_W'(1)) begin
              fire[i]   = 1'b1;
              st_nxt[i] = IFEL_IDLE;
            end
            dly_nxt[i] = dly_r[i] - 1'b1;
          end
        end
        default: begin
          st_nxt[i] = IFEL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 2*NQ; i++) begin
        st_r[i]  <= IFEL_IDLE;
        dly_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 2*NQ; i++) begin
        st_r[i]  <= st_nxt[i];
        dly_r[i] <= dly_nxt[i];
      end
    end
  end

  // --------------------------------------------------------------
  // pulse latches and outputs
  // --------------------------------------------------------------
  logic [NI-1:0] latch_r;
  logic [NI-1:0] latch_nxt;
  ifel_irq_t     irq_r;
  ifel_irq_t     irq_nxt;
  logic [NI-1:0] filt_out_r;
  logic [NI-1:0] filt_out_nxt;
  logic [NI-1:0] flag_out_r;
  logic [NI-1:0] flag_out_nxt;

  always_comb begin
    // set wins over a clear in the same cycle
    latch_nxt    = (latch_r & ~pulse_latch_clear) | rise_ev;
    irq_nxt.rise = fire[NQ-1:0];
    irq_nxt.fall = fire[2*NQ-1:NQ];
    filt_out_nxt = filt;
    // blanking is registered so every output leaves a flop; the latch itself is kept
    flag_out_nxt = latch_nxt;
    if (watchdog_timeout) begin
      irq_nxt      = '0;
      filt_out_nxt = '0;
      flag_out_nxt = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_r    <= '0;
      irq_r      <= '0;
      filt_out_r <= '0;
      flag_out_r <= '0;
    end else begin
      latch_r    <= latch_nxt;
      irq_r      <= irq_nxt;
      filt_out_r <= filt_out_nxt;
      flag_out_r <= flag_out_nxt;
    end
  end

  assign edge_irq_vector  = irq_r;
  assign filtered_input   = filt_out_r;
  assign pulse_latch_flag = flag_out_r;
endmodule : ifel_top
`default_nettype wire

/* tb/ifel_top_monitor.sv */
// Purpose: port checks for ifel_top
// Assumes: sim filter >= 50 cycles
// Notes:   two cycles after reset or watchdog are skipped
`timescale 1ns/100ps
`default_nettype none
`include "ifel_consts.svh"
module ifel_top_monitor
  import ifel_pkg::*;
#(
  parameter int NI = 8,
  parameter int NQ = 6
) (
  input wire logic                     core_clk,
  input wire logic                     rst_b,
  input wire logic [NI-1:0]            fast_input_pin,
  input wire logic [NQ-1:0]            edge_irq_disable_flag,
  input wire logic [`IFEL_DELAY_W-1:0] irq_delay_ms,
  input wire logic [NI-1:0]            pulse_latch_clear,
  input wire logic                     watchdog_timeout,
  input wire logic [NI-1:0]            filtered_input,
  input wire ifel_irq_t                edge_irq_vector,
  input wire logic [NI-1:0]            pulse_latch_flag
);
  // ------
  // checks
  // ------
  logic [1:0] wd_r;
  logic       live;
  // starts busy so $past never sees reset or blanked values
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b) wd_r <= 2'h3;
    else wd_r <= {wd_r[0], watchdog_timeout};
  assign live = !watchdog_timeout && wd_r == 2'h0;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  property p_wd;
    watchdog_timeout && wd_r[0] |-> {filtered_input, edge_irq_vector, pulse_latch_flag} == '0;
  endproperty
  a_wd: assert property (p_wd) else $error("output on in watchdog");
  property p_one;
    live |-> (edge_irq_vector & $past(edge_irq_vector)) == '0;
  endproperty
  a_one: assert property (p_one) else $error("irq pulse too long");
  property p_dis;
    ((edge_irq_vector.rise | edge_irq_vector.fall) & edge_irq_disable_flag
      & $past(edge_irq_disable_flag)) == '0;
  endproperty
  a_dis: assert property (p_dis) else $error("irq while disabled");
  property p_now;
    live && irq_delay_ms == 0 && $past(irq_delay_ms) == 0 && $stable(edge_irq_disable_flag) |->
      edge_irq_vector.rise == (filtered_input[NQ-1:0] & ~$past(filtered_input[NQ-1:0])
        & ~edge_irq_disable_flag) && edge_irq_vector.fall == (~filtered_input[NQ-1:0]
        & $past(filtered_input[NQ-1:0]) & ~edge_irq_disable_flag);
  endproperty
  a_now: assert property (p_now) else $error("irq not on edge");
  property p_lset;
    live |-> (filtered_input & ~$past(filtered_input) & ~pulse_latch_flag) == '0;
  endproperty
  a_lset: assert property (p_lset) else $error("latch missed");
  property p_lhold;
    live |-> ($past(pulse_latch_flag) & ~$past(pulse_latch_clear) & ~pulse_latch_flag) == '0;
  endproperty
  a_lhold: assert property (p_lhold) else $error("latch lost");
  property p_lcause;
    live |-> (pulse_latch_flag & ~$past(pulse_latch_flag) & ~filtered_input) == '0;
  endproperty
  a_lcause: assert property (p_lcause) else $error("latch set alone");
  property p_filt;
    live |-> (filtered_input & ~$past(filtered_input)
      & ~($past(fast_input_pin, 4) & $past(fast_input_pin, 40))) == '0;
  endproperty
  a_filt: assert property (p_filt) else $error("filter too short");
  c_rise: cover property (live && |edge_irq_vector.rise);
  c_fall: cover property (live && |edge_irq_vector.fall);
  c_latch: cover property (live && |pulse_latch_flag);
endmodule : ifel_top_monitor
bind ifel_top ifel_top_monitor #(.NI(NI), .NQ(NQ)) i_ifel_top_monitor (.core_clk, .rst_b,
  .fast_input_pin, .edge_irq_disable_flag, .irq_delay_ms, .pulse_latch_clear,
  .watchdog_timeout, .filtered_input, .edge_irq_vector, .pulse_latch_flag);
`default_nettype wire

/* tb/ifel_pins_model.sv */
// Purpose: sensors driving the fast input pins
// Assumes: driven levels are clean
// Notes:   none
`timescale 1ns/100ps
`default_nettype none
module ifel_pins_model (
  input  wire logic      core_clk,
  output var logic [7:0] pin
);
  initial pin = 8'h00;
  // each level stands n cycles; short holds only where a glitch is meant
  task automatic drive(input logic [7:0] v, input int n);
    @(posedge core_clk) pin <= v;
    repeat (n - 1) @(posedge core_clk);
  endtask : drive
endmodule : ifel_pins_model
`default_nettype wire

/* tb/ifel_top_bench.sv */
// Purpose: self-checking bench for ifel_top
// Assumes: filter 50 and tick 20 cycles in sim
// Notes:   pins come from the sensor model
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module ifel_top_bench
  import ifel_pkg::*;
;
  logic       core_clk, rst_b, wd;
  logic [7:0] pin, ca, clr, fi, pl, dly;
  logic [5:0] dis, rs, fs;
  ifel_irq_t  irq;
  int         error_cnt, checked;
  int         acc_cut, acc_seen;
  ifel_pins_model i_ifel_pins_model (.core_clk, .pin);
  ifel_top #(.DEF_CYC(20'h32), .STEP_CYC(20'h14)) i_ifel_top (.core_clk, .rst_b,
    .fast_input_pin(pin), .counter_assign(ca), .edge_irq_disable_flag(dis), .irq_delay_ms(dly),
    .pulse_latch_clear(clr), .watchdog_timeout(wd), .filtered_input(fi),
    .edge_irq_vector(irq), .pulse_latch_flag(pl));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // a new window after each see keeps only this edge's pulses; one driver per sticky
  always @(posedge core_clk) begin
    if (!rst_b || acc_seen != acc_cut) begin
      rs <= irq.rise;
      fs <= irq.fall;
    end else begin
      rs <= rs | irq.rise;
      fs <= fs | irq.fall;
    end
    acc_seen <= acc_cut;
  end
  task automatic see(input logic [7:0] efi, epl, input logic [5:0] ers, efs);
    @(negedge core_clk);
    `CHK("filtered", efi, fi)
    `CHK("latch", epl, pl)
    `CHK("rise", ers, rs)
    `CHK("fall", efs, fs)
    acc_cut++;
  endtask : see
  task automatic results;
    if (error_cnt == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results
  // -----
  // tests
  // -----
  initial begin
    {rst_b, wd, ca, dis, dly, clr} = '0;
    error_cnt = 0;
    checked = 0;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    i_ifel_pins_model.drive(8'hff, 20);
    i_ifel_pins_model.drive(8'h00, 100);
    see(8'h00, 8'h00, 6'h00, 6'h00);
    i_ifel_pins_model.drive(8'hff, 100);
    see(8'hff, 8'hff, 6'h3f, 6'h00);
    i_ifel_pins_model.drive(8'h00, 100);
    see(8'h00, 8'hff, 6'h00, 6'h3f);
    @(posedge core_clk) clr <= 8'h0f;
    @(posedge core_clk) clr <= 8'h00;
    see(8'h00, 8'hf0, 6'h00, 6'h00);
    @(posedge core_clk) dis <= 6'h15;
    i_ifel_pins_model.drive(8'hff, 100);
    see(8'hff, 8'hff, 6'h2a, 6'h00);
    i_ifel_pins_model.drive(8'h00, 100);
    see(8'h00, 8'hff, 6'h00, 6'h2a);
    @(posedge core_clk) {dis, dly} <= {6'h00, 8'h03};
    i_ifel_pins_model.drive(8'hff, 80);
    see(8'hff, 8'hff, 6'h00, 6'h00);
    repeat (50) @(posedge core_clk);
    see(8'hff, 8'hff, 6'h3f, 6'h00);
    i_ifel_pins_model.drive(8'h00, 130);
    see(8'h00, 8'hff, 6'h00, 6'h3f);
    // a disable raised while a delay is pending cancels that interrupt
    i_ifel_pins_model.drive(8'hff, 60);
    @(posedge core_clk) dis <= 6'h3f;
    @(posedge core_clk) dis <= 6'h00;
    repeat (80) @(posedge core_clk);
    see(8'hff, 8'hff, 6'h00, 6'h00);
    i_ifel_pins_model.drive(8'h00, 130);
    see(8'h00, 8'hff, 6'h00, 6'h3f);
    // counter inputs have their irqs disabled here so no input has two functions
    @(posedge core_clk) {ca, dis, dly} <= {8'hff, 6'h3f, 8'h00};
    i_ifel_pins_model.drive(8'hff, 400);
    see(8'h00, 8'hff, 6'h00, 6'h00);
    repeat (200) @(posedge core_clk);
    see(8'h3f, 8'hff, 6'h00, 6'h00);
    repeat (4500) @(posedge core_clk);
    see(8'hff, 8'hff, 6'h00, 6'h00);
    i_ifel_pins_model.drive(8'h00, 5100);
    see(8'h00, 8'hff, 6'h00, 6'h00);
    // edges under watchdog: filter and latch run on, outputs and irq stay off
    @(posedge core_clk) {ca, dis, wd} <= {8'h00, 6'h00, 1'b1};
    i_ifel_pins_model.drive(8'hff, 100);
    see(8'h00, 8'h00, 6'h00, 6'h00);
    @(posedge core_clk) wd <= 1'b0;
    repeat (3) @(posedge core_clk);
    see(8'hff, 8'hff, 6'h00, 6'h00);
    results();
  end
  initial begin
    repeat (30000) @(posedge core_clk);
    error_cnt++;
    results();
  end
endmodule : ifel_top_bench
`default_nettype wire
